// ==== hw/tmr_pkg.sv ====
// Package with register map, field layout and timing constants of the auto-reload timer
package tmr_pkg;
  localparam logic [7:0] TMR_CTRL_ADDR = 8'hC8;
  localparam logic [7:0] TMR_RELOAD_LOW_ADDR = 8'hCA;
  localparam logic [7:0] TMR_RELOAD_HIGH_ADDR = 8'hCB;
  localparam logic [7:0] TMR_COUNT_LOW_ADDR = 8'hCC;
  localparam logic [7:0] TMR_COUNT_HIGH_ADDR = 8'hCD;
  localparam int TMR_HI_FLAG_BIT = 7;
  localparam int TMR_LO_FLAG_BIT = 6;
  localparam int TMR_LO_IEN_BIT = 5;
  localparam int TMR_CAP_EN_BIT = 4;
  localparam int TMR_SPLIT_BIT = 3;
  localparam int TMR_RUN_BIT = 2;
  localparam int TMR_XCLK_BIT = 0;
  localparam logic [7:0] TMR_BYTE_RESET = 8'h00;
  localparam logic [3:0] TMR_SYS_DIV = 4'hC;
  localparam logic [2:0] TMR_EXT_DIV = 3'h7;
  localparam logic [7:0] TMR_BYTE_MAX = 8'hFF;

  typedef struct packed {
    logic hi_flag;
    logic lo_flag;
    logic lo_ien;
    logic cap_en;
    logic split;
    logic run;
    logic xclk;
  } tmr_ctrl_type;

  localparam tmr_ctrl_type TMR_CTRL_RESET = '0;
endpackage

// ==== hw/tmr_sync_edge.sv ====
// Two-flop synchroniser with edge pulse for one asynchronous pin
`timescale 1ns/1ns
module tmr_sync_edge
  import tmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic falling_i,
  output logic edge_o
);
  logic meta;
  logic sync;
  logic last;
  logic next_edge;

  always_comb begin
    next_edge = falling_i ? (last & ~sync) : (~last & sync);
  end

  // Only the second stage and its delayed copy feed the edge detector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
      edge_o <= next_edge;
    end
  end
endmodule

// ==== hw/tmr_timer.sv ====
// Auto-reload timer with split and capture modes behind a byte-wide register port
`timescale 1ns/1ns
module tmr_timer
  import tmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic ext_clk_i,
  input wire logic capture_input_pin_i,
  input wire logic high_byte_clock_select_i,
  input wire logic low_byte_clock_select_i,
  input wire logic timer_irq_enable_i,
  output logic irq_o
);
  tmr_ctrl_type ctrl;
  tmr_ctrl_type next_ctrl;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic [7:0] counter_low_byte;
  logic [7:0] counter_high_byte;
  logic [7:0] next_reload_low_byte;
  logic [7:0] next_reload_high_byte;
  logic [7:0] next_counter_low_byte;
  logic [7:0] next_counter_high_byte;
  logic [3:0] sys_div;
  logic [3:0] next_sys_div;
  logic [2:0] ext_div;
  logic [2:0] next_ext_div;
  logic ext_rise;
  logic cap_fall;
  logic sys_tick;
  logic ext_tick;
  logic base_tick;
  logic tick_low;
  logic tick_high;
  logic low_wrap;
  logic high_wrap;
  logic set_hi;
  logic set_lo;
  logic [7:0] next_rdata;
  logic next_irq;

  tmr_sync_edge u_ext_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_clk_i),
    .falling_i(1'b0),
    .edge_o(ext_rise)
  );

  tmr_sync_edge u_cap_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(capture_input_pin_i),
    .falling_i(1'b1),
    .edge_o(cap_fall)
  );

  // Prescalers free-run so a clock switch takes effect on the next base tick
  always_comb begin
    sys_tick = (sys_div == TMR_SYS_DIV - 4'h1);
    next_sys_div = sys_tick ? 4'h0 : sys_div + 4'h1;
    ext_tick = ext_rise && (ext_div == TMR_EXT_DIV);
    next_ext_div = ext_rise ? ext_div + 3'h1 : ext_div;
    base_tick = ctrl.xclk ? ext_tick : sys_tick;
    // Byte clock select 1 bypasses the prescaler and counts every system clock; the low byte select acts in split mode only
    tick_low = low_byte_clock_select_i ? 1'b1 : base_tick;
    tick_high = high_byte_clock_select_i ? 1'b1 : base_tick;
  end

  always_comb begin
    next_ctrl = ctrl;
    next_reload_low_byte = reload_low_byte;
    next_reload_high_byte = reload_high_byte;
    next_counter_low_byte = counter_low_byte;
    next_counter_high_byte = counter_high_byte;
    low_wrap = 1'b0;
    high_wrap = 1'b0;
    set_hi = 1'b0;
    set_lo = 1'b0;
    if (ctrl.split) begin
      // Low byte ignores the run bit in split mode
      if (tick_low) begin
        low_wrap = (counter_low_byte == TMR_BYTE_MAX);
        next_counter_low_byte = counter_low_byte + 8'h01;
      end
      if (ctrl.run && tick_high) begin
        high_wrap = (counter_high_byte == TMR_BYTE_MAX);
        next_counter_high_byte = counter_high_byte + 8'h01;
      end
      if (low_wrap && !ctrl.cap_en) begin
        next_counter_low_byte = reload_low_byte;
      end
      if (high_wrap && !ctrl.cap_en) begin
        next_counter_high_byte = reload_high_byte;
      end
    end else if (ctrl.run && tick_high) begin
      low_wrap = (counter_low_byte == TMR_BYTE_MAX);
      high_wrap = low_wrap && (counter_high_byte == TMR_BYTE_MAX);
      {next_counter_high_byte, next_counter_low_byte} = {counter_high_byte, counter_low_byte} + 16'h0001;
      if (high_wrap && !ctrl.cap_en) begin
        next_counter_low_byte = reload_low_byte;
        next_counter_high_byte = reload_high_byte;
      end
    end
    set_lo = low_wrap;
    set_hi = high_wrap;
    // Capture reuses the high flag so software can see and clear the event
    if (ctrl.cap_en && cap_fall) begin
      next_reload_low_byte = counter_low_byte;
      next_reload_high_byte = counter_high_byte;
      set_hi = 1'b1;
    end
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        TMR_CTRL_ADDR: begin
          next_ctrl.hi_flag = sfr_wdata_i[TMR_HI_FLAG_BIT];
          next_ctrl.lo_flag = sfr_wdata_i[TMR_LO_FLAG_BIT];
          next_ctrl.lo_ien = sfr_wdata_i[TMR_LO_IEN_BIT];
          next_ctrl.cap_en = sfr_wdata_i[TMR_CAP_EN_BIT];
          next_ctrl.split = sfr_wdata_i[TMR_SPLIT_BIT];
          next_ctrl.run = sfr_wdata_i[TMR_RUN_BIT];
          next_ctrl.xclk = sfr_wdata_i[TMR_XCLK_BIT];
        end
        TMR_RELOAD_LOW_ADDR: begin
          next_reload_low_byte = sfr_wdata_i;
        end
        TMR_RELOAD_HIGH_ADDR: begin
          next_reload_high_byte = sfr_wdata_i;
        end
        TMR_COUNT_LOW_ADDR: begin
          next_counter_low_byte = sfr_wdata_i;
        end
        TMR_COUNT_HIGH_ADDR: begin
          next_counter_high_byte = sfr_wdata_i;
        end
        default: begin
        end
      endcase
    end
    // A hardware event in the same cycle as a software clear still lands
    next_ctrl.hi_flag = next_ctrl.hi_flag | set_hi;
    next_ctrl.lo_flag = next_ctrl.lo_flag | set_lo;
  end

  always_comb begin
    case (sfr_addr_i)
      TMR_CTRL_ADDR: begin
        next_rdata = 8'h00;
        next_rdata[TMR_HI_FLAG_BIT] = ctrl.hi_flag;
        next_rdata[TMR_LO_FLAG_BIT] = ctrl.lo_flag;
        next_rdata[TMR_LO_IEN_BIT] = ctrl.lo_ien;
        next_rdata[TMR_CAP_EN_BIT] = ctrl.cap_en;
        next_rdata[TMR_SPLIT_BIT] = ctrl.split;
        next_rdata[TMR_RUN_BIT] = ctrl.run;
        next_rdata[TMR_XCLK_BIT] = ctrl.xclk;
      end
      TMR_RELOAD_LOW_ADDR: begin
        next_rdata = reload_low_byte;
      end
      TMR_RELOAD_HIGH_ADDR: begin
        next_rdata = reload_high_byte;
      end
      TMR_COUNT_LOW_ADDR: begin
        next_rdata = counter_low_byte;
      end
      TMR_COUNT_HIGH_ADDR: begin
        next_rdata = counter_high_byte;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Level request; stays up until software clears the flag or the enable drops
  always_comb begin
    next_irq = timer_irq_enable_i && (ctrl.hi_flag || (ctrl.lo_flag && ctrl.lo_ien));
  end

  // Dividers never stop, so the first count after run lands within one period, not after a full one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_div <= 4'h0;
      ext_div <= 3'h0;
    end else begin
      sys_div <= next_sys_div;
      ext_div <= next_ext_div;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= TMR_CTRL_RESET;
      reload_low_byte <= TMR_BYTE_RESET;
      reload_high_byte <= TMR_BYTE_RESET;
      counter_low_byte <= TMR_BYTE_RESET;
      counter_high_byte <= TMR_BYTE_RESET;
    end else begin
      ctrl <= next_ctrl;
      reload_low_byte <= next_reload_low_byte;
      reload_high_byte <= next_reload_high_byte;
      counter_low_byte <= next_counter_low_byte;
      counter_high_byte <= next_counter_high_byte;
    end
  end

  // Read data and request leave straight from flops so the port never glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      sfr_rdata_o <= next_rdata;
      irq_o <= next_irq;
    end
  end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the auto-reload timer
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic [7:0] d;
  logic sfr_wr_i = 0;
  logic ext_clk_i = 0;
  logic cap_i = 1;
  logic hsel = 1;
  logic lsel = 1;
  logic ien = 0;
  logic irq_o;
  int bad_count = 0;
  int n_checks = 0;
  logic [7:0] fv[3] = '{8'h80, 8'h60, 8'h42};
  logic fx[3] = '{1'b1, 1'b1, 1'b0};
  tmr_timer u_tmr_timer (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .ext_clk_i(ext_clk_i), .capture_input_pin_i(cap_i),
    .high_byte_clock_select_i(hsel), .low_byte_clock_select_i(lsel), .timer_irq_enable_i(ien), .irq_o(irq_o));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wr_i <= 1'b1;
    sfr_wdata_i <= v;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  // Read data is registered, so it is taken one edge after the address
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    sfr_addr_i <= a;
    @(posedge clk_i);
    #1 d = sfr_rdata_o;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wait_irq;
    for (int i = 0; i < 64 && irq_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (irq_o !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask
  initial begin
    cyc(2);
    rst_i <= 1'b0;
    foreach (fv[i]) rd(8'hC8 + 8'(i));
    for (int a = 8'hC8; a < 8'hCE; a++) begin
      rd(8'(a));
      `CHK(d, 8'h00)
    end
    $display("reset done");
    @(posedge clk_i) ien <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(8'hC8, fv[i]);
      cyc(2);
      #1 `CHK(irq_o, fx[i])
      rd(8'hC8);
      `CHK(d, fv[i] & 8'hFD)
      wr(8'hC8, 8'h00);
    end
    $display("flags done");
    wr(8'hCA, 8'hF0);
    wr(8'hCB, 8'hFF);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    cyc(6);
    rd(8'hC8);
    `CHK(d, 8'hC4)
    `CHK(irq_o, 1'b1)
    wr(8'hC8, 8'h00);
    rd(8'hCD);
    `CHK(d, 8'hFF)
    rd(8'hCA);
    `CHK(d, 8'hF0)
    rd(8'hCC);
    `CHK(d, 8'hF8)
    $display("wrap16 done");
    wr(8'hCD, 8'h10);
    wr(8'hCC, 8'hF8);
    wr(8'hCA, 8'h80);
    wr(8'hC8, 8'h28);
    wait_irq();
    rd(8'hC8);
    `CHK(d, 8'h68)
    rd(8'hCD);
    `CHK(d, 8'h10)
    rd(8'hCC);
    `CHK(d, 8'h86)
    wr(8'hC8, 8'h00);
    $display("split done");
    wr(8'hCD, 8'h12);
    wr(8'hCC, 8'h00);
    wr(8'hC8, 8'h14);
    @(posedge clk_i) cap_i <= 1'b0;
    cyc(10);
    rd(8'hCB);
    `CHK(d, 8'h12)
    rd(8'hC8);
    `CHK(d, 8'h94)
    `CHK(irq_o, 1'b1)
    rd(8'hCA);
    `CHK(d, 8'h04)
    wr(8'hC8, 8'h00);
    $display("capture done");
    hsel <= 1'b0;
    wr(8'hCC, 8'h00);
    wr(8'hC8, 8'h05);
    repeat (16) begin
      @(posedge clk_i) ext_clk_i <= 1'b1;
      cyc(2);
      @(posedge clk_i) ext_clk_i <= 1'b0;
      cyc(2);
    end
    cyc(6);
    rd(8'hCC);
    `CHK(d, 8'h02)
    wr(8'hC8, 8'h00);
    wr(8'hCC, 8'h00);
    wr(8'hC8, 8'h04);
    cyc(118);
    wr(8'hC8, 8'h00);
    rd(8'hCC);
    `CHK(d, 8'h0A)
    $display("clocks done");
    wr(8'hCC, 8'h00);
    lsel <= 1'b0;
    wr(8'hC8, 8'h08);
    cyc(118);
    wr(8'hC8, 8'h00);
    rd(8'hCC);
    `CHK(d, 8'h0A)
    $display("split prescale done");
    wr(8'hC8, 8'hA4);
    @(posedge clk_i) rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    #1 `CHK(irq_o, 1'b0)
    rd(8'hC8);
    `CHK(d, 8'h00)
    rd(8'hCC);
    `CHK(d, 8'h00)
    $display("second reset done");
    summarize();
  end
endmodule

// ==== test/tmr_timer_chk.sv ====
// Port-level assertions for the auto-reload timer
`timescale 1ns/1ns
module tmr_timer_chk
  import tmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic timer_irq_enable_i,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Reads may tear only through writes, so two quiet reads bracket the flag
  sequence s_quiet;
    !sfr_wr_i && sfr_addr_i == TMR_CTRL_ADDR;
  endsequence
  sequence s_wr_ctrl;
    sfr_wr_i && sfr_addr_i == TMR_CTRL_ADDR;
  endsequence
  sequence s_idle_en;
    !sfr_wr_i && timer_irq_enable_i;
  endsequence
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && sfr_rdata_o == 8'h00) else $error("not clear");
  a_irq_gated: assert property (!timer_irq_enable_i |=> !irq_o) else $error("irq without enable");
  a_unmapped_zero: assert property (!(sfr_addr_i inside {[8'hCA:8'hCD], 8'hC8}) |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read");
  a_reserved_zero: assert property (sfr_addr_i == TMR_CTRL_ADDR |=> !sfr_rdata_o[1]) else $error("bit1");
  a_ctrl_keeps: assert property (s_wr_ctrl ##1 s_quiet |=> sfr_rdata_o[5:0] == ($past(sfr_wdata_i, 2) & 8'h3D))
    else $error("ctrl bits lost");
  a_hi_sticky: assert property (s_quiet ##1 (s_quiet ##0 sfr_rdata_o[7]) |=> sfr_rdata_o[7]) else $error("hi clr");
  a_lo_sticky: assert property (s_quiet ##1 (s_quiet ##0 sfr_rdata_o[6]) |=> sfr_rdata_o[6]) else $error("lo clr");
  a_hi_irq: assert property ((s_wr_ctrl ##0 sfr_wdata_i[7]) ##1 s_idle_en |=> irq_o)
    else $error("no hi irq");
  a_lo_irq: assert property ((s_wr_ctrl ##0 sfr_wdata_i[6:5] == 2'h3) ##1 s_idle_en |=> irq_o)
    else $error("no lo irq");
endmodule
bind tmr_timer tmr_timer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .timer_irq_enable_i(timer_irq_enable_i), .irq_o(irq_o));
